/* point_cmd_input.sv */
// point command input port: strobe decode, inhibits, servo enable, multi-function inputs
//
// Notes on behaviour
// - max point minus one jogs forward fast
// - max point minus two jogs reverse fast
// - open ccw inhibit blocks ccw commands
// - open cw inhibit blocks cw commands
// - inhibit enable, polarity, stop mode settable
// - home sensor closed means near; invertible
// - servo enable closed gives servo on
// - servo enable open cuts motor power
// - servo-off sequence picks brake and clear
// - servo enable input can be made invalid
// - strobe closing starts move to point
// - each multi input assignable to six functions
// - each multi input has own polarity
// - maximum point code returns axis home
// - point code zero clears the alarm
// - point code binary weighted, polarity settable
// - busy transistor off while command processing
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "point_cmd_regs.svh"

module point_cmd_input
	import point_cmd_pkg::*;
#(
	parameter int PT_BITS = 6  // width of the point code
) (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// contact inputs, 1 = closed to the common return
	input  wire logic        point_select_bit0,
	input  wire logic        point_select_bit1,
	input  wire logic        point_select_bit2,
	input  wire logic        point_select_bit3,
	input  wire logic        point_select_bit4,
	input  wire logic        point_select_bit5,
	input  wire logic        command_strobe,
	input  wire logic        ccw_travel_inhibit,
	input  wire logic        cw_travel_inhibit,
	input  wire logic        home_sensor_in,
	input  wire logic        servo_enable_in,
	input  wire logic        multi_function_in_a,
	input  wire logic        multi_function_in_b,
	// motion engine handshake
	input  wire logic        motion_done,
	// AXI4-Lite slave
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// outputs toward the drive
	output logic             busy_on,
	output cmd_t             cmd,
	output logic             cmd_start,
	output logic             servo_on,
	output logic             dyn_brake,
	output logic             clear_deviation,
	output logic             block_ccw,
	output logic             block_cw,
	output logic             inhibit_stop_mode,
	output logic             near_home,
	output mf_req_t          mf_req
);

	// ==========================================
	// elaboration checks
	if (PT_BITS != 6) begin : g_bad_width
		$error("point_cmd_input serves a 6-bit point code only");
	end

	// ==========================================
	// reset release
	logic       rst_meta;        // first stage
	logic       rst_n;           // released reset

	// two flops release the reset to the core clock
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ==========================================
	// helpers
	// contact level to active level under a polarity bit
	function automatic logic act(input logic closed, input logic pol_closed);
		act = pol_closed ? closed : ~closed;
	endfunction

	// ==========================================
	// registers
	logic [31:0] ctrl;           // control settings
	logic [31:0] mfcfg;          // multi-function settings
	logic [5:0]  last_point;     // code of the last accepted command
	cmd_kind_t   last_kind;      // kind of the last accepted command

	logic [2:0]  pt_bits;        // point code width in use
	logic [5:0]  max_point;      // highest point code
	assign pt_bits   = ctrl[`CTRL_BITS_LSB +: `CTRL_BITS_W];
	assign max_point = 6'(7'((1 << pt_bits) - 1));

	// ==========================================
	// contact decode
	logic [5:0]  raw_code;       // closed contacts, weights 1..32
	logic [5:0]  code;           // code after polarity and width
	logic        stb_act;        // strobe closed
	logic        stb_prev;       // strobe of last cycle
	logic        servo_act;      // servo enable asserted
	logic        ccw_open;       // ccw inhibit active
	logic        cw_open;        // cw inhibit active

	assign raw_code = {point_select_bit5, point_select_bit4, point_select_bit3,
		point_select_bit2, point_select_bit1, point_select_bit0};

	// binary weights, polarity and width masking
	always_comb begin
		code = (ctrl[`CTRL_PT_POL] ? raw_code : ~raw_code) & max_point;
	end

	assign stb_act   = command_strobe;
	// servo enable ignored when made invalid
	assign servo_act = ctrl[`CTRL_SRV_VALID] ? servo_enable_in : 1'b1;
	// inhibits count when enabled; polarity bit 0 means open is active
	assign ccw_open  = ctrl[`CTRL_CCW_EN] & act(ccw_travel_inhibit, ctrl[`CTRL_INH_POL]);
	assign cw_open   = ctrl[`CTRL_CW_EN] & act(cw_travel_inhibit, ctrl[`CTRL_INH_POL]);

	// ==========================================
	// multi-function inputs
	logic [1:0]  mf_act;         // per-input active level
	mf_func_t    mf_fn [2];      // per-input function
	assign mf_act[0] = act(multi_function_in_a, mfcfg[`MF_POL_A]);
	assign mf_act[1] = act(multi_function_in_b, mfcfg[`MF_POL_B]);
	assign mf_fn[0]  = mf_func_t'(mfcfg[`MF_FUNC_A_LSB +: `MF_FUNC_W]);
	assign mf_fn[1]  = mf_func_t'(mfcfg[`MF_FUNC_B_LSB +: `MF_FUNC_W]);

	mf_req_t     mf_part [2];    // request from each input
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_mf
			// map an asserted input onto its function
			always_comb begin
				mf_part[gi]             = '0;
				mf_part[gi].inst_stop   = mf_act[gi] && mf_fn[gi] == MF_INST_STOP;
				mf_part[gi].temp_stop   = mf_act[gi] && mf_fn[gi] == MF_TEMP_STOP;
				mf_part[gi].decel_stop  = mf_act[gi] && mf_fn[gi] == MF_DECEL_STOP;
				mf_part[gi].jog_fwd     = mf_act[gi] && mf_fn[gi] == MF_JOG_FWD && !ccw_open;
				mf_part[gi].jog_rev     = mf_act[gi] && mf_fn[gi] == MF_JOG_REV && !cw_open;
				mf_part[gi].alarm_clear = mf_act[gi] && mf_fn[gi] == MF_ALARM_CLEAR;
			end
		end
	endgenerate

	// ==========================================
	// strobe command decode
	cmd_t        next_cmd;       // command for the sampled code
	logic        cmd_blocked;    // refused by an inhibit

	always_comb begin
		next_cmd.point = code;
		cmd_blocked    = 1'b0;
		if (code == 6'h00) begin
			next_cmd.kind = CMD_ALARM_CLEAR;
		end else if (code == max_point) begin
			next_cmd.kind = CMD_HOME;
		end else if (code == 6'(max_point - 6'h01)) begin
			next_cmd.kind = CMD_JOG_FWD;
			cmd_blocked   = ccw_open;
		end else if (code == 6'(max_point - 6'h02)) begin
			next_cmd.kind = CMD_JOG_REV;
			cmd_blocked   = cw_open;
		end else begin
			next_cmd.kind = CMD_MOVE_POINT;
		end
	end

	// ==========================================
	// command sequencer
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_HOLD
	} seq_t;
	seq_t        state;          // sequencer state
	logic        take;           // accept this strobe edge

	assign take = state == ST_IDLE && stb_act && !stb_prev && servo_act;

	// strobe edge memory
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stb_prev <= 1'b0;
		end else begin
			stb_prev <= stb_act;
		end
	end

	// idle, processing, then wait for strobe release
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (take && !cmd_blocked) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (motion_done || !servo_act) begin
						state <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					// busy stays off until the strobe opens
					if (!stb_act) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// command latch and start pulse
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd        <= '{kind: CMD_NONE, point: 6'h00};
			cmd_start  <= 1'b0;
			last_point <= 6'h00;
			last_kind  <= CMD_NONE;
		end else begin
			cmd_start <= take && !cmd_blocked;
			if (take && !cmd_blocked) begin
				cmd        <= next_cmd;
				last_point <= next_cmd.point;
				last_kind  <= next_cmd.kind;
			end
		end
	end

	// ==========================================
	// drive-facing outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_on           <= 1'b1;
			servo_on          <= 1'b0;
			dyn_brake         <= 1'b0;
			clear_deviation   <= 1'b0;
			block_ccw         <= 1'b0;
			block_cw          <= 1'b0;
			inhibit_stop_mode <= 1'b0;
			near_home         <= 1'b0;
			mf_req            <= '0;
		end else begin
			// a refused strobe leaves busy untouched
			busy_on           <= state == ST_IDLE && !(take && !cmd_blocked);
			servo_on          <= servo_act;
			dyn_brake         <= !servo_act && ctrl[`CTRL_SEQ_DB];
			clear_deviation   <= !servo_act && ctrl[`CTRL_SEQ_CLR];
			block_ccw         <= ccw_open;
			block_cw          <= cw_open;
			inhibit_stop_mode <= ctrl[`CTRL_INH_STOP];
			near_home         <= act(home_sensor_in, !ctrl[`CTRL_HOME_POL]);
			mf_req            <= mf_part[0] | mf_part[1];
		end
	end

	// ==========================================
	// bus write channel
	logic        aw_held;        // address taken
	logic        w_held;         // data taken
	logic [7:0]  aw_addr;        // held address
	logic [31:0] w_data;         // held data
	logic [3:0]  w_strb;         // held strobes

	// merge byte lanes into a register
	function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		for (int i = 0; i < 4; i++) begin
			old[8*i +: 8] = st[i] ? nw[8*i +: 8] : old[8*i +: 8];
		end
		lanes = old;
	endfunction

	// take address and data in either order, answer after both
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			ctrl          <= `CTRL_RESET;
			mfcfg         <= `MFCFG_RESET;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RESP_OKAY;
				if (aw_addr == `REG_CTRL_OFS) begin
					ctrl <= lanes(ctrl, w_data, w_strb) & 32'h0000_0FFF;
				end else if (aw_addr == `REG_MFCFG_OFS) begin
					mfcfg <= lanes(mfcfg, w_data, w_strb) & 32'h0000_00FF;
				end else if (aw_addr == `REG_STATUS_OFS || aw_addr == `REG_LAST_OFS) begin
					s_axi_bresp <= `RESP_OKAY;
				end else begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// bus read channel
	logic [31:0] status_word;    // live state for software

	always_comb begin
		status_word      = 32'h0000_0000;
		status_word[0]   = state != ST_IDLE;
		status_word[1]   = servo_act;
		status_word[2]   = near_home;
		status_word[3]   = ccw_open;
		status_word[4]   = cw_open;
		status_word[5]   = stb_act;
		status_word[7:6] = state;
		status_word[13:8] = code;
	end

	// one read at a time, answered the cycle after the address
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RESP_OKAY;
				if (s_axi_araddr == `REG_CTRL_OFS) begin
					s_axi_rdata <= ctrl;
				end else if (s_axi_araddr == `REG_MFCFG_OFS) begin
					s_axi_rdata <= mfcfg;
				end else if (s_axi_araddr == `REG_STATUS_OFS) begin
					s_axi_rdata <= status_word;
				end else if (s_axi_araddr == `REG_LAST_OFS) begin
					s_axi_rdata <= {21'h000000, 3'(last_kind), 2'h0, last_point};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

/* point_cmd_regs.svh */
// register offsets, field positions and reset values for the point command port
`ifndef POINT_CMD_REGS_SVH
`define POINT_CMD_REGS_SVH

// ==========================================
// register byte offsets
`define REG_CTRL_OFS        8'h00
`define REG_MFCFG_OFS       8'h04
`define REG_STATUS_OFS      8'h08
`define REG_LAST_OFS        8'h0C

// ==========================================
// control register fields
`define CTRL_BITS_LSB       0
`define CTRL_BITS_W         3
`define CTRL_PT_POL         3
`define CTRL_HOME_POL       4
`define CTRL_SRV_VALID      5
`define CTRL_SEQ_DB         6
`define CTRL_SEQ_CLR        7
`define CTRL_CCW_EN         8
`define CTRL_CW_EN          9
`define CTRL_INH_POL        10
`define CTRL_INH_STOP       11
`define CTRL_RESET          32'h0000_0B2E

// ==========================================
// multi-function config fields
`define MF_FUNC_W           3
`define MF_FUNC_A_LSB       0
`define MF_FUNC_B_LSB       3
`define MF_POL_A            6
`define MF_POL_B            7
`define MFCFG_RESET         32'h0000_00C0

// ==========================================
// bus answers
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* point_cmd_pkg.sv */
// types shared by the point command input block
package point_cmd_pkg;

	// kind of command taken from a strobe
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_ALARM_CLEAR,
		CMD_MOVE_POINT,
		CMD_JOG_FWD,
		CMD_JOG_REV,
		CMD_HOME
	} cmd_kind_t;

	// function assigned to a multi-function input
	typedef enum logic [2:0] {
		MF_NONE,
		MF_INST_STOP,
		MF_TEMP_STOP,
		MF_DECEL_STOP,
		MF_JOG_FWD,
		MF_JOG_REV,
		MF_ALARM_CLEAR
	} mf_func_t;

	// command handed to the motion engine
	typedef struct packed {
		cmd_kind_t  kind;
		logic [5:0] point;
	} cmd_t;

	// stop, jog and alarm-clear requests from the multi-function inputs
	typedef struct packed {
		logic inst_stop;
		logic temp_stop;
		logic decel_stop;
		logic jog_fwd;
		logic jog_rev;
		logic alarm_clear;
	} mf_req_t;

endpackage

/* point_cmd_input_props.sv */
// assertions on the point command port
`timescale 1ns/1ps
module point_cmd_input_props
	import point_cmd_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic command_strobe,
	input wire logic servo_enable_in,
	input wire logic busy_on,
	input wire cmd_t cmd,
	input wire logic cmd_start,
	input wire logic servo_on
);
	// ==========================================
	// clocking and step sequences
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// strobe closed after a cycle open
	sequence s_fresh_edge;
		$past(command_strobe) && !$past(command_strobe, 2);
	endsequence
	// port was idle when the edge came
	sequence s_was_idle;
		$past(busy_on);
	endsequence
	// ==========================================
	// strobe take and busy
	start_on_edge_a: assert property (cmd_start |-> s_fresh_edge)
		else $error("start without a fresh strobe edge");
	start_when_idle_a: assert property (cmd_start |-> s_was_idle)
		else $error("start while a command was running");
	start_drops_busy_a: assert property (cmd_start |-> !busy_on)
		else $error("busy still on at command start");
	start_single_a: assert property (cmd_start |=> !cmd_start)
		else $error("start longer than one cycle");
	busy_cause_a: assert property ($fell(busy_on) |-> cmd_start)
		else $error("busy fell without a command");
	busy_hold_a: assert property (!busy_on && command_strobe |=> !busy_on)
		else $error("busy back while strobe closed");
	busy_release_a: assert property ($rose(busy_on) |-> !$past(command_strobe))
		else $error("busy back before strobe opened");
	cmd_hold_a: assert property ($changed(cmd) |-> cmd_start)
		else $error("command changed without start");
	// ==========================================
	// servo enable
	servo_rise_a: assert property ($rose(servo_enable_in) |-> ##[1:4] servo_on)
		else $error("servo did not turn on");
	servo_fall_a: assert property ($fell(servo_enable_in) |-> ##[1:4] !servo_on)
		else $error("servo did not turn off");
	start_seen_c: cover property (cmd_start);
endmodule
bind point_cmd_input point_cmd_input_props point_cmd_input_props_i (.*);

/* host_contacts.sv */
// host controller model driving the point code and strobe contacts
`timescale 1ns/1ps
module host_contacts #(
	parameter int HOLD = 4  // shortened settle and strobe hold
) (
	input  wire logic core_clk,
	input  wire logic busy_on,
	output logic [5:0] code_pins,
	output logic       strobe
);
	// contacts open at power up
	initial begin
		code_pins = 6'h00;
		strobe = 1'b0;
	end
	// ==========================================
	// one strobed command
	task automatic issue(input logic [5:0] raw);
		int n;
		n = 0;
		@(posedge core_clk);
		code_pins <= raw;
		repeat (HOLD) @(posedge core_clk);
		strobe <= 1'b1;
		// keep strobe until busy answers or 20 cycles pass
		while (busy_on !== 1'b0 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		repeat (HOLD) @(posedge core_clk);
		strobe <= 1'b0;
	endtask
endmodule

/* test_point_command_input_interface.sv */
// self-checking bench for the point command port
`timescale 1ns/1ps
`include "point_cmd_regs.svh"
module test_point_command_input_interface
	import point_cmd_pkg::*;
;
	// ==========================================
	// signals, inputs start at rest
	logic        core_clk = 1'b0, arst_n = 1'b0, motion_done = 1'b0, command_strobe;
	logic        ccw_travel_inhibit = 1'b1, cw_travel_inhibit = 1'b1, home_sensor_in = 1'b1;
	logic        servo_enable_in = 1'b1, multi_function_in_a = 1'b0, multi_function_in_b = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic        busy_on, cmd_start, servo_on, dyn_brake, clear_deviation;
	logic        block_ccw, block_cw, inhibit_stop_mode, near_home;
	logic [5:0]  pins;
	cmd_t        cmd;
	mf_req_t     mf_req;
	int          miscompares = 0, cmp_count = 0, starts = 0;
	logic [31:0] seed = 32'h0000_0014;
	logic [5:0]  wide [4] = '{6'h00, 6'h3F, 6'h3E, 6'h3D};
	logic [5:0]  narrow [5] = '{6'h07, 6'h06, 6'h05, 6'h00, 6'h03};

	host_contacts host_contacts_i (.core_clk(core_clk), .busy_on(busy_on), .code_pins(pins),
		.strobe(command_strobe));
	point_cmd_input point_cmd_input_i (.point_select_bit0(pins[0]), .point_select_bit1(pins[1]),
		.point_select_bit2(pins[2]), .point_select_bit3(pins[3]), .point_select_bit4(pins[4]),
		.point_select_bit5(pins[5]), .*);

	// ==========================================
	// clock, start counter, watchdog
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (cmd_start === 1'b1) starts <= starts + 1;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		conclude();
	end

	// ==========================================
	// helpers
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// special codes sit at zero and at the top of the range
	function automatic cmd_kind_t kind_of(input int code, input int bits);
		int mx;
		mx = (1 << bits) - 1;
		if (code == 0) return CMD_ALARM_CLEAR;
		if (code == mx) return CMD_HOME;
		if (code == mx - 1) return CMD_JOG_FWD;
		if (code == mx - 2) return CMD_JOG_REV;
		return CMD_MOVE_POINT;
	endfunction
	task automatic settle();
		repeat (6) @(negedge core_clk);
	endtask
	// bus write, answer code left in rr
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// only the watchdog ends this wait
		do begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// bus read into rd and rr
	task automatic axr(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		// only the watchdog ends this wait
		do begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// motion engine ends the command, wait for idle
	task automatic finish_cmd();
		int n;
		n = 0;
		@(posedge core_clk);
		motion_done <= 1'b1;
		@(posedge core_clk);
		motion_done <= 1'b0;
		while (busy_on !== 1'b1 && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		check("busy back", busy_on, 1'b1);
	endtask
	// strobe one code, expect it taken or dropped
	task automatic run(input logic [5:0] code, input int bits, input logic pol, input logic take);
		int n0;
		logic [5:0] mask;
		n0 = starts;
		mask = 6'((1 << bits) - 1);
		host_contacts_i.issue(pol ? code : ~code);
		if (take) finish_cmd();
		check("taken", starts - n0, 32'(take));
		if (take) check("kind", cmd.kind, kind_of(code & mask, bits));
		if (take) check("point", cmd.point, code & mask);
	endtask

	// ==========================================
	// main sequence
	initial begin
		int n0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		settle();
		axr(`REG_CTRL_OFS);
		check("ctrl reset", rd, `CTRL_RESET);
		axr(`REG_MFCFG_OFS);
		check("mfcfg reset", rd, `MFCFG_RESET);
		axr(8'h10);
		check("unmapped read", rr, `RESP_SLVERR);
		axw(8'h20, 32'h0000_00FF);
		check("unmapped write", rr, `RESP_SLVERR);
		axw(`REG_CTRL_OFS, 32'hFFFF_FB6E);
		check("write answer", rr, `RESP_OKAY);
		axr(`REG_CTRL_OFS);
		check("ctrl", rd, 32'h0000_0B6E);
		check("servo on", servo_on, 1'b1);
		check("near home", near_home, 1'b1);
		foreach (wide[i]) run(wide[i], 6, 1'b1, 1'b1);
		repeat (6) run(6'(xs() % 60 + 1), 6, 1'b1, 1'b1);
		// second strobe while running is dropped
		n0 = starts;
		host_contacts_i.issue(6'h05);
		host_contacts_i.issue(6'h06);
		check("repeat", starts - n0, 32'd1);
		finish_cmd();
		check("first kept", cmd.point, 6'h05);
		// open inhibits refuse the matching jog
		@(posedge core_clk);
		ccw_travel_inhibit <= 1'b0;
		settle();
		check("ccw blocked", block_ccw, 1'b1);
		run(6'h3E, 6, 1'b1, 1'b0);
		run(6'h3D, 6, 1'b1, 1'b1);
		@(posedge core_clk);
		cw_travel_inhibit <= 1'b0;
		settle();
		check("cw blocked", block_cw, 1'b1);
		run(6'h3D, 6, 1'b1, 1'b0);
		axw(`REG_CTRL_OFS, 32'h0000_002E);
		run(6'h3E, 6, 1'b1, 1'b1);
		check("stop mode off", inhibit_stop_mode, 1'b0);
		@(posedge core_clk);
		ccw_travel_inhibit <= 1'b1;
		cw_travel_inhibit <= 1'b1;
		// three code bits, open contacts valid, home inverted
		axw(`REG_CTRL_OFS, 32'h0000_0BF3);
		settle();
		check("home inverted", near_home, 1'b0);
		check("stop mode on", inhibit_stop_mode, 1'b1);
		foreach (narrow[i]) run(narrow[i], 3, 1'b0, 1'b1);
		@(posedge core_clk);
		servo_enable_in <= 1'b0;
		settle();
		check("servo off", servo_on, 1'b0);
		check("brake", dyn_brake, 1'b1);
		check("clear", clear_deviation, 1'b1);
		run(6'h03, 3, 1'b0, 1'b0);
		// servo enable made invalid forces servo on
		axw(`REG_CTRL_OFS, 32'h0000_0BD3);
		settle();
		check("servo forced", servo_on, 1'b1);
		axw(`REG_CTRL_OFS, 32'h0000_0BF3);
		settle();
		check("servo off again", servo_on, 1'b0);
		@(posedge core_clk);
		servo_enable_in <= 1'b1;
		repeat (8) @(posedge core_clk);
		check("servo back", servo_on, 1'b1);
		check("brake off", dyn_brake, 1'b0);
		run(6'h04, 3, 1'b0, 1'b1);
		axr(`REG_LAST_OFS);
		check("last", rd, (32'(CMD_MOVE_POINT) << 8) | 32'h0000_0004);
		// every multi-function assignment on input a
		for (int f = 1; f <= 6; f++) begin
			axw(`REG_MFCFG_OFS, 32'h0000_00C0 | f);
			multi_function_in_a <= 1'b1;
			settle();
			check("mf function", mf_req, 32'(1 << (6 - f)));
		end
		axw(`REG_MFCFG_OFS, 32'h0000_0071);
		multi_function_in_a <= 1'b0;
		multi_function_in_b <= 1'b1;
		settle();
		check("mf idle", mf_req, 32'h0);
		@(posedge core_clk);
		multi_function_in_b <= 1'b0;
		settle();
		check("mf open active", mf_req, 32'h1);
		conclude();
	end
endmodule
